// *** core/ipl_pkg.sv ***
// Package for the interrupt priority level register bank.
// Assumes a 32-bit AXI4-Lite register bus; each register is one aligned word.
package ipl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_CAN      = 4'h3;
  localparam logic [3:0] IDX_SER_GPIO = 4'h4;
  localparam logic [3:0] IDX_SER_COMM = 4'h5;
  localparam logic [3:0] IDX_TMR_DEC  = 4'h6;
  localparam logic [3:0] IDX_TIMERS   = 4'h7;
  localparam int         ADDR_LSB     = 2;
  localparam int         IDX_W        = 4;
  localparam int         NUM_REQ      = 22; // Every field in the bank drives one request line

  // Writable bit masks per register; all other bits read zero
  localparam logic [15:0] MASK_CAN      = 16'h03FC;
  localparam logic [15:0] MASK_SER_GPIO = 16'hFC3F;
  localparam logic [15:0] MASK_SER_COMM = 16'h0F3F;
  localparam logic [15:0] MASK_TMR_DEC  = 16'hC00F;
  localparam logic [15:0] MASK_TIMERS   = 16'hC03F;
  localparam logic [15:0] RESET_VALUE   = 16'h0000;

  // Field and bus response encodings
  localparam logic [1:0] FIELD_DISABLED = 2'h0;
  localparam logic [1:0] AXI_OKAY       = 2'h0;
  localparam logic [1:0] AXI_SLVERR     = 2'h2;

  typedef struct packed {
    logic        active;
    logic [1:0]  level;
  } ipl_decoded_type;

  typedef struct packed {
    logic [15:0] can;
    logic [15:0] ser_gpio;
    logic [15:0] ser_comm;
    logic [15:0] tmr_dec;
    logic [15:0] timers;
  } ipl_bank_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_held;
    logic        w_held;
    logic [IDX_W-1:0] aw_idx;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    ipl_bank_type bank;
    logic [NUM_REQ-1:0] req_out;
    logic [2*NUM_REQ-1:0] lvl_out;
  } ipl_state_type;

endpackage

// *** core/ipl_field_decode.sv ***
// Decodes one 2-bit priority field into an enable and a level of 0 to 2.
// Assumes the field comes from the register bank in the same clock domain.
`timescale 1ns/1ps
module ipl_field_decode (
  input  wire logic [1:0]             field,
  output ipl_pkg::ipl_decoded_type    decoded
);
  // Encodings above the disabled code step down by one, so 11 maps to level 2 at most
  always_comb begin
    decoded.active = (field != ipl_pkg::FIELD_DISABLED);
    decoded.level  = decoded.active ? 2'(field - 2'h1) : 2'h0;
  end
endmodule

// *** core/ipl_regs.sv ***
// Interrupt priority level registers for CAN, serial, GPIO, timer and decoder requests.
// Assumes an AXI4-Lite master on sys_clk and peripheral requests synchronous to sys_clk.
//
// Operation
// - Each 2-bit field decodes 00 as disabled and 01, 10, 11 as levels 0, 1 and 2.
// - No field encoding can place a request above level 2.
// - Every field resets to the disabled code so nothing is forwarded until programmed.
// - Unimplemented bits read as zero and ignore writes.
// - The CAN register holds message buffer 9-8, wake-up 7-6, error 5-4, bus-off 3-2.
// - Offset 4 holds serial port 0 rx-full 15-14, port 1 tx-empty 13-12, port 1 rx-full 11-10.
// - Offset 4 holds I/O port A 5-4, port B 3-2 and port C 1-0.
// - Offset 5 holds comm 1 rx-full 11-10 and rx-error 9-8.
// - Offset 5 holds comm 1 tx-idle 5-4, tx-empty 3-2 and serial port 0 tx-empty 1-0.
// - Offset 6 holds timer C ch0 15-14, decoder index 3-2 and home/watchdog 1-0.
// - Offset 7 holds timer A ch0 15-14 and timer C channels 3, 2, 1 in bits 5-0.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module ipl_regs (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,

  // Write address channel
  input  wire logic [31:0]                s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,

  // Write data channel; only the low two byte lanes carry register bits
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,

  // Write response channel
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,

  // Read address channel
  input  wire logic [31:0]                s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,

  // Read data channel; upper half of the word is always zero
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,

  // Raw requests in, gated requests and their levels out to arbitration
  input  wire logic [ipl_pkg::NUM_REQ-1:0] periph_req,
  output logic [ipl_pkg::NUM_REQ-1:0]     arb_req,
  output logic [2*ipl_pkg::NUM_REQ-1:0]   arb_level
);

  ipl_pkg::ipl_state_type             state;
  ipl_pkg::ipl_state_type             next_state;
  logic [2*ipl_pkg::NUM_REQ-1:0]      fields;
  ipl_pkg::ipl_decoded_type           dec [ipl_pkg::NUM_REQ];
  logic [ipl_pkg::IDX_W-1:0]          ar_idx;

  // Field behind each request, in request index order; slot i gates periph_req[i]
  // Timer register: timer C channels 1, 2 and 3, then timer A channel 0
  assign fields[1:0]   = state.bank.timers[1:0];
  assign fields[3:2]   = state.bank.timers[3:2];
  assign fields[5:4]   = state.bank.timers[5:4];
  assign fields[7:6]   = state.bank.timers[15:14];

  // Timer and decoder register: home or watchdog, index pulse, timer C channel 0
  assign fields[9:8]   = state.bank.tmr_dec[1:0];
  assign fields[11:10] = state.bank.tmr_dec[3:2];
  assign fields[13:12] = state.bank.tmr_dec[15:14];

  // Serial communication register; bits 7-6 and 15-12 hold nothing
  assign fields[15:14] = state.bank.ser_comm[1:0];
  assign fields[17:16] = state.bank.ser_comm[3:2];
  assign fields[19:18] = state.bank.ser_comm[5:4];
  assign fields[21:20] = state.bank.ser_comm[9:8];
  assign fields[23:22] = state.bank.ser_comm[11:10];

  // Serial peripheral and I/O port register; bits 9-6 hold nothing
  assign fields[25:24] = state.bank.ser_gpio[1:0];
  assign fields[27:26] = state.bank.ser_gpio[3:2];
  assign fields[29:28] = state.bank.ser_gpio[5:4];
  assign fields[31:30] = state.bank.ser_gpio[11:10];
  assign fields[33:32] = state.bank.ser_gpio[13:12];
  assign fields[35:34] = state.bank.ser_gpio[15:14];

  // CAN register: bus-off, error, wake-up, message buffer; all four reach arbitration
  assign fields[37:36] = state.bank.can[3:2];
  assign fields[39:38] = state.bank.can[5:4];
  assign fields[41:40] = state.bank.can[7:6];
  assign fields[43:42] = state.bank.can[9:8];

  assign ar_idx = s_axi_araddr[ipl_pkg::ADDR_LSB +: ipl_pkg::IDX_W];

  // One decoder per request field
  generate
    for (genvar i = 0; i < ipl_pkg::NUM_REQ; i++) begin : g_dec
      ipl_field_decode u_dec (
        .field   (fields[2*i +: 2]),
        .decoded (dec[i])
      );
    end
  endgenerate

  // Read mux; unmapped addresses flagged for an error response
  function automatic logic [16:0] read_word(input ipl_pkg::ipl_bank_type b, input logic [3:0] idx);
    logic [16:0] r;
    r = {1'b1, 16'h0000};
    case (idx)
      ipl_pkg::IDX_CAN:      r = {1'b0, b.can};
      ipl_pkg::IDX_SER_GPIO: r = {1'b0, b.ser_gpio};
      ipl_pkg::IDX_SER_COMM: r = {1'b0, b.ser_comm};
      ipl_pkg::IDX_TMR_DEC:  r = {1'b0, b.tmr_dec};
      ipl_pkg::IDX_TIMERS:   r = {1'b0, b.timers};
      default:               r = {1'b1, 16'h0000};
    endcase
    return r;
  endfunction

  // Byte-lane merge limited to the writable mask
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] st, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{st[1]}}, {8{st[0]}}} & mask;
    return (old & ~lanes) | (wd[15:0] & lanes);
  endfunction

  // Bus slave and register next-state logic
  always_comb begin
    logic [16:0] rd;
    logic        wr_go;
    rd         = read_word(state.bank, ar_idx);
    wr_go      = 1'b0;
    next_state = state;

    // Address and data are taken independently, ready drops once each is held
    if (s_axi_awvalid && state.awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_idx  = s_axi_awaddr[ipl_pkg::ADDR_LSB +: ipl_pkg::IDX_W];
      next_state.awready = 1'b0;
    end
    if (s_axi_wvalid && state.wready) begin
      next_state.w_held = 1'b1;
      next_state.wdata  = s_axi_wdata;
      next_state.wstrb  = s_axi_wstrb;
      next_state.wready = 1'b0;
    end

    // Commit once both halves are held and the previous response is gone
    if (state.aw_held && state.w_held && !state.bvalid) begin
      wr_go              = 1'b1;
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = ipl_pkg::AXI_OKAY;
      case (state.aw_idx)
        ipl_pkg::IDX_CAN: begin
          // Four CAN fields; bits 1-0 and 15-10 stay zero
          next_state.bank.can = merge(state.bank.can, state.wdata, state.wstrb, ipl_pkg::MASK_CAN);
        end
        ipl_pkg::IDX_SER_GPIO: begin
          // Serial peripheral fields high, I/O port fields low
          next_state.bank.ser_gpio = merge(state.bank.ser_gpio, state.wdata, state.wstrb,
                                           ipl_pkg::MASK_SER_GPIO);
        end
        ipl_pkg::IDX_SER_COMM: begin
          // Receive fields at 11-8, transmit fields at 5-0
          next_state.bank.ser_comm = merge(state.bank.ser_comm, state.wdata, state.wstrb,
                                           ipl_pkg::MASK_SER_COMM);
        end
        ipl_pkg::IDX_TMR_DEC: begin
          // Timer field at the top, decoder fields at the bottom
          next_state.bank.tmr_dec = merge(state.bank.tmr_dec, state.wdata, state.wstrb,
                                          ipl_pkg::MASK_TMR_DEC);
        end
        ipl_pkg::IDX_TIMERS: begin
          // Timer A at the top, three timer C channels at the bottom
          next_state.bank.timers = merge(state.bank.timers, state.wdata, state.wstrb,
                                         ipl_pkg::MASK_TIMERS);
        end
        default: begin
          // Unmapped index: nothing changes, software sees an error answer
          next_state.bresp = ipl_pkg::AXI_SLVERR;
        end
      endcase
    end

    // Response handshake reopens both write channels
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid  = 1'b0;
      next_state.awready = 1'b1;
      next_state.wready  = 1'b1;
    end

    // Reads: one outstanding, arready low while the answer waits
    if (s_axi_arvalid && state.arready) begin
      next_state.arready = 1'b0;
      next_state.rvalid  = 1'b1;
      next_state.rdata   = {16'h0000, rd[15:0]};
      next_state.rresp   = rd[16] ? ipl_pkg::AXI_SLVERR : ipl_pkg::AXI_OKAY;
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid  = 1'b0;
      next_state.arready = 1'b1;
    end

    // Registered outputs to arbitration, gated by the field enable
    for (int i = 0; i < ipl_pkg::NUM_REQ; i++) begin
      next_state.req_out[i]       = periph_req[i] & dec[i].active;
      next_state.lvl_out[2*i +: 2] = dec[i].active ? dec[i].level : 2'h0;
    end

    if (!wr_go) begin
      next_state.bank = next_state.bank; // Bank only changes on a committed write
    end
  end

  // State register; every field cleared to disabled at reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state               <= '0;
      state.awready       <= 1'b1;
      state.wready        <= 1'b1;
      state.arready       <= 1'b1;
      state.bank.can      <= ipl_pkg::RESET_VALUE;
      state.bank.ser_gpio <= ipl_pkg::RESET_VALUE;
      state.bank.ser_comm <= ipl_pkg::RESET_VALUE;
      state.bank.tmr_dec  <= ipl_pkg::RESET_VALUE;
      state.bank.timers   <= ipl_pkg::RESET_VALUE;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state flops
  assign s_axi_awready = state.awready;
  assign s_axi_wready  = state.wready;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = state.arready;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;
  assign arb_req       = state.req_out;
  assign arb_level     = state.lvl_out;

endmodule

// *** sim/ipl_regs_monitor.sv ***
// Checker for the priority level register bank ports.
// Assumes a bind onto ipl_regs, everything on sys_clk.
`timescale 1ns/1ps
module ipl_regs_monitor (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [21:0] periph_req,
  input wire logic [21:0] arb_req,
  input wire logic [43:0] arb_level
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic lvl_bad;
  // Any slot showing code 3 would mean a level above 2
  always_comb begin
    lvl_bad = 1'b0;
    for (int i = 0; i < 22; i++) begin
      if (arb_level[2*i +: 2] == 2'h3) lvl_bad = 1'b1;
    end
  end
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  level_range_a: assert property (!lvl_bad) else $error("level above 2");
  req_gate_a: assert property ((arb_req & ~$past(periph_req)) == '0) else $error("ungated req");
  reset_quiet_a: assert property ($rose(rst_n) |-> arb_req == '0 && arb_level == '0) else $error("not idle");
  write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("no write answer");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000) else $error("bad read");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == '0) else $error("err data");
endmodule

// *** sim/ipl_periph_model.sv ***
// Request source standing in for the interrupting peripherals.
// Assumes level requests synchronous to sys_clk.
`timescale 1ns/1ps
module ipl_periph_model (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  output logic [ipl_pkg::NUM_REQ-1:0] periph_req
);
  // Requests change at random, often holding so stable levels are seen too
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_req <= '0;
    end else if ($urandom_range(0, 2) == 0) begin
      periph_req <= ipl_pkg::NUM_REQ'($urandom);
    end
  end
endmodule

// *** sim/tb_top.sv ***
// Top bench: AXI4-Lite master, scoreboard and request model.
// Assumes the package, design, model and monitor compile first.
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [31:0] awaddr  = '0;
  logic [31:0] wdata   = '0;
  logic [31:0] araddr  = '0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [21:0] periph_req, arb_req, prev_req;
  logic [43:0] arb_level;
  logic [15:0] sh [3:7]  = '{default: 16'h0000};
  logic [15:0] msk [3:7] = '{16'h03FC, 16'hFC3F, 16'h0F3F, 16'hC00F, 16'hC03F};
  logic [7:0]  map [22]  = '{8'h70, 8'h72, 8'h74, 8'h7E, 8'h60, 8'h62, 8'h6E, 8'h50, 8'h52, 8'h54,
                             8'h58, 8'h5A, 8'h40, 8'h42, 8'h44, 8'h4A, 8'h4C, 8'h4E, 8'h32, 8'h34,
                             8'h36, 8'h38};
  logic [33:0] expq [$];
  int          errors   = 0;
  int          compares = 0;

  always #2 sys_clk = ~sys_clk;

  ipl_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .periph_req(periph_req),
    .arb_req(arb_req), .arb_level(arb_level));
  ipl_periph_model peer (.sys_clk(sys_clk), .rst_n(rst_n), .periph_req(periph_req));

  task automatic check(input string what, input logic [43:0] seen, input logic [43:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [33:0] expect_rd(input logic [3:0] idx);
    return (idx inside {[3:7]}) ? {18'h0, sh[idx]} : {2'h2, 32'h0};
  endfunction

  // One write; unmapped places expect an error answer and no change
  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    int n;
    @(posedge sys_clk);
    awaddr <= {26'h0, idx, 2'h0};
    wdata <= {16'hA5A5, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    if (idx inside {[3:7]}) sh[idx] = d & msk[idx];
    expq.push_back((idx inside {[3:7]}) ? 34'h0 : {2'h2, 32'h0});
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 40) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic rd(input logic [3:0] idx);
    int n;
    @(posedge sys_clk);
    araddr <= {26'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    expq.push_back(expect_rd(idx));
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 40) begin
      errors++;
      complete_run();
    end
  endtask

  // Outputs lag the sampled requests by one cycle
  always @(posedge sys_clk) prev_req <= periph_req;

  // Scoreboard: each answer takes the oldest expectation
  always @(posedge sys_clk) begin
    if (bvalid && bready) check("bresp", {10'h0, bresp, 32'h0}, {10'h0, expq.pop_front()});
    if (rvalid && rready) check("rdata", {10'h0, rresp, rdata}, {10'h0, expq.pop_front()});
  end

  task automatic arb_chk();
    logic [21:0] er;
    logic [43:0] el;
    logic [1:0]  f;
    repeat (2) @(posedge sys_clk);
    repeat (6) begin
      @(negedge sys_clk);
      for (int i = 0; i < 22; i++) begin
        f = sh[map[i][7:4]][map[i][3:0] +: 2];
        er[i] = prev_req[i] && f != 2'h0;
        el[2*i +: 2] = (f == 2'h0) ? 2'h0 : f - 2'h1;
      end
      check("arb_req", {22'h0, arb_req}, {22'h0, er});
      check("arb_level", arb_level, el);
    end
  endtask

  // Reset values, every code in every field, then random patterns
  initial begin
    void'($urandom(48189));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 3; i < 9; i++) rd(i[3:0]);
    for (int k = 0; k < 12; k++) begin
      for (int i = 3; i < 9; i++) wr(i[3:0], (k < 4) ? {8{k[1:0]}} : 16'($urandom));
      for (int i = 3; i < 9; i++) rd(i[3:0]);
      arb_chk();
    end
    complete_run();
  end
endmodule

bind ipl_regs ipl_regs_monitor mon (.sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
  .s_axi_rresp, .periph_req, .arb_req, .arb_level);
